// >>> hdl/aux_pin_interface.sv
// Auxiliary pin block: programmable I/O, interrupts, straps
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module aux_pin_interface (
    input wire logic mclk,
    input wire logic rst,
    input wire aux_pkg::aux_req_s req,
    output logic [7:0] rdata,
    input wire logic [2:0] mode_strap,
    input wire logic data_clock_fast,
    input wire logic [7:0] pin_i,
    output aux_pkg::aux_pin_drv_s pin,
    output logic [1:0] pullup_en,
    input wire logic frame_sync,
    input wire logic bit_clock,
    input wire logic channel_tick,
    input wire logic stop_go_in,
    input wire logic marker_tx,
    output logic marker_rx,
    output logic [2:0] timeslot_offset,
    output logic channel_invalid,
    output logic own_channel,
    output logic irq
);
    import aux_pkg::*;

    // Software-visible registers
    logic [7:0] pin_direction_reg;    // 1 = input
    logic [7:0] pin_output_reg;       // Value for output pins
    logic [7:0] pin_drive_config_reg; // 1 = push-pull
    logic [5:0] pin_function_config_reg;
    logic [1:0] pin_irq_status_reg;   // Sticky, bit 0 is pin 6
    logic [1:0] pin_irq_mask_reg;     // 1 = masked

    // Strap capture
    aux_mode_e op_mode;               // Latched operating mode
    logic [2:0] chan_strap;           // Latched channel straps
    logic line_mode;                  // Pins 0-2 are channel straps

    // Interrupt pin front end
    logic [1:0] int_meta;             // First synchroniser stage
    logic [1:0] int_sync;             // Second stage
    logic [1:0] int_prev;             // Delayed copy for edges
    logic [1:0] trig;                 // Trigger condition per pin
    logic [1:0] level_sel;            // 1 = level triggered

    // Frame slot counter
    logic [2:0] slot_cnt;             // Current channel in frame

    // Decoded register port accesses
    logic wr_hit;
    logic rd_stat;
    logic [7:0] next_o;
    logic [7:0] next_oe;
    logic marker_out_mode;

    assign wr_hit = req.wr;
    assign rd_stat = req.rd && (req.addr == AUX_OFS_IRQ_STAT);

    // Straps are sampled while reset is held, never by the reset itself
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            op_mode <= aux_mode_e'(mode_strap);
            chan_strap <= pin_i[2:0];
        end
    end

    // Channel-strap role of pins 0-2 in the AUX_TRUNK_LT, AUX_SUBSCR_LT and AUX_NET_TERM modes
    assign line_mode = (op_mode == AUX_TRUNK_LT) ||
                       (op_mode == AUX_SUBSCR_LT) ||
                       (op_mode == AUX_NET_TERM); // RULE_01

    // Marker is sent in the subscriber and trunk modes, else received
    assign marker_out_mode = (op_mode == AUX_SUBSCRIBER) ||
                             (op_mode == AUX_TRUNK_LT); // RULE_15

    // Register writes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_direction_reg <= AUX_RST_DIR; // RULE_02
            pin_output_reg <= AUX_RST_OUT;
            pin_drive_config_reg <= AUX_RST_DRV;
            pin_function_config_reg <= AUX_RST_FUNC;
            pin_irq_mask_reg <= AUX_RST_MASK; // RULE_09
        end
        else if (wr_hit)
        begin
            case (req.addr)
                AUX_OFS_DIR: pin_direction_reg <= req.wdata;
                AUX_OFS_OUT: pin_output_reg <= req.wdata;
                AUX_OFS_DRV: pin_drive_config_reg <= req.wdata;
                AUX_OFS_FUNC: pin_function_config_reg <= req.wdata[5:0];
                AUX_OFS_IRQ_MASK: pin_irq_mask_reg <= req.wdata[1:0];
                default:
                begin
                    // Read-only and unmapped offsets ignore writes
                end
            endcase
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else if (req.rd)
        begin
            case (req.addr)
                AUX_OFS_DIR: rdata <= pin_direction_reg;
                AUX_OFS_OUT: rdata <= pin_output_reg;
                // Pin level latched at the read, outputs included
                AUX_OFS_IN: rdata <= pin_i; // RULE_03 RULE_06
                AUX_OFS_DRV: rdata <= pin_drive_config_reg;
                AUX_OFS_FUNC: rdata <= {2'h0, pin_function_config_reg};
                AUX_OFS_IRQ_STAT: rdata <= {6'h00, pin_irq_status_reg};
                AUX_OFS_IRQ_MASK: rdata <= {6'h00, pin_irq_mask_reg};
                AUX_OFS_STRAP: rdata <= {channel_invalid, line_mode,
                                         op_mode, chan_strap};
                default: rdata <= 8'h00;
            endcase
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

    // Pin driver selection before the output flops
    always_comb
    begin
        next_o = 8'h00;
        next_oe = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (!pin_direction_reg[i])
            begin
                if (pin_drive_config_reg[i])
                begin
                    // Push-pull drives both levels
                    next_o[i] = pin_output_reg[i]; // RULE_04
                    next_oe[i] = 1'b1; // RULE_05
                end
                else
                begin
                    // Open-drain only pulls low
                    next_o[i] = 1'b0;
                    next_oe[i] = !pin_output_reg[i]; // RULE_05
                end
            end
        end
        if (line_mode)
        begin
            next_o[2:0] = 3'h0; // RULE_01
            next_oe[2:0] = 3'h0;
        end
        if (pin_function_config_reg[AUX_FN_PIN4])
        begin
            // General I/O settings of pin 4 are ignored here
            next_o[4] = marker_out_mode ? marker_tx : 1'b0; // RULE_14
            next_oe[4] = marker_out_mode; // RULE_15
        end
        if (pin_function_config_reg[AUX_FN_PIN5])
        begin
            next_o[5] = pin_function_config_reg[AUX_FN_SRC] ?
                        bit_clock : frame_sync; // RULE_07 RULE_08
            next_oe[5] = 1'b1;
        end
        if (pin_function_config_reg[AUX_FN_PIN7])
        begin
            next_o[7] = stop_go_in; // RULE_13
            next_oe[7] = 1'b1;
        end
    end

    // Pin outputs come from flops: one cycle after a register write
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin.o <= 8'h00;
            pin.oe <= 8'h00; // RULE_02
        end
        else
        begin
            pin.o <= next_o;
            pin.oe <= next_oe;
        end
    end

    // Pull-ups on pins 6 and 7 follow their actual driver type
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pullup_en <= 2'h3;
        end
        else
        begin
            pullup_en <= ~(next_oe[7:6] &
                           {pin_drive_config_reg[7] ||
                            pin_function_config_reg[AUX_FN_PIN7],
                            pin_drive_config_reg[6]}); // RULE_12
        end
    end

    // Received marker level when the pin is a marker input
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            marker_rx <= 1'b0;
        end
        else
        begin
            marker_rx <= pin_function_config_reg[AUX_FN_PIN4] &&
                         !marker_out_mode && pin_i[4]; // RULE_15
        end
    end

    // Two-flop synchroniser; int_sync and its delayed copy int_prev feed the trigger logic
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            int_meta <= 2'h3;
            int_sync <= 2'h3;
            int_prev <= 2'h3;
        end
        else
        begin
            int_meta <= pin_i[7:6]; // RULE_20
            int_sync <= int_meta; // RULE_20
            int_prev <= int_sync;
        end
    end

    // Active-low trigger: falling edge, or low level
    assign level_sel = {pin_function_config_reg[AUX_FN_TRIG_B],
                        pin_function_config_reg[AUX_FN_TRIG_A]};
    assign trig = pin_direction_reg[7:6] &
                  ((level_sel & ~int_sync) |
                   (~level_sel & int_prev & ~int_sync)); // RULE_10 RULE_11

    // Sticky status: a trigger wins over the clearing read
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_irq_status_reg <= 2'h0;
        end
        else if (rd_stat)
        begin
            pin_irq_status_reg <= trig; // RULE_21
        end
        else
        begin
            pin_irq_status_reg <= pin_irq_status_reg | trig; // RULE_10
        end
    end

    // Host interrupt, registered so it has no glitches
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(pin_irq_status_reg & ~pin_irq_mask_reg); // RULE_10
        end
    end

    // Channel offset and its validity for the data clock rate
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            timeslot_offset <= 3'h0;
            channel_invalid <= 1'b0;
        end
        else
        begin
            timeslot_offset <= line_mode ? chan_strap : 3'h0; // RULE_16 RULE_18
            channel_invalid <= line_mode && !data_clock_fast &&
                               (chan_strap > AUX_SLOW_MAX_CH); // RULE_17
        end
    end

    // Slot counter: frame sync restarts, each tick steps one channel
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            slot_cnt <= 3'h0;
        end
        else if (frame_sync)
        begin
            slot_cnt <= 3'h0; // RULE_19
        end
        else if (channel_tick)
        begin
            slot_cnt <= slot_cnt + 3'h1; // RULE_19
        end
    end

    // Marks the slot that carries this device's channel
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            own_channel <= 1'b0;
        end
        else
        begin
            own_channel <= (slot_cnt == timeslot_offset); // RULE_18
        end
    end

    // Checks
    sequence s_pp_out3;
        !pin_direction_reg[3] && pin_drive_config_reg[3];
    endsequence

    sequence s_rd_in;
        req.rd && (req.addr == AUX_OFS_IN);
    endsequence

    property p_reset_inputs;
        @(posedge mclk) rst |=> (pin.oe == 8'h00);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) // RULE_02
        else $error("pins not all inputs after reset");

    property p_push_pull;
        @(posedge mclk) disable iff (rst)
        s_pp_out3 |=> pin.oe[3] && (pin.o[3] == $past(pin_output_reg[3]));
    endproperty
    a_push_pull: assert property (p_push_pull) // RULE_05
        else $error("push-pull pin 3 wrong");

    property p_open_drain;
        @(posedge mclk) disable iff (rst)
        (!pin_direction_reg[3] && !pin_drive_config_reg[3]) |=>
            !pin.o[3] && (pin.oe[3] == !$past(pin_output_reg[3]));
    endproperty
    a_open_drain: assert property (p_open_drain) // RULE_05
        else $error("open-drain pin 3 wrong");

    property p_read_level;
        @(posedge mclk) disable iff (rst)
        s_rd_in |=> (rdata == $past(pin_i));
    endproperty
    a_read_level: assert property (p_read_level) // RULE_03
        else $error("input read not the pin level");

    property p_strap_pins;
        @(posedge mclk) disable iff (rst)
        line_mode |=> (pin.oe[2:0] == 3'h0);
    endproperty
    a_strap_pins: assert property (p_strap_pins) // RULE_01
        else $error("strap pin driven");

    property p_alt_frame;
        @(posedge mclk) disable iff (rst)
        (pin_function_config_reg[AUX_FN_PIN5] &&
         !pin_function_config_reg[AUX_FN_SRC]) |=>
            pin.oe[5] && (pin.o[5] == $past(frame_sync));
    endproperty
    a_alt_frame: assert property (p_alt_frame) // RULE_08
        else $error("pin 5 not frame sync");

    property p_stop_go;
        @(posedge mclk) disable iff (rst)
        pin_function_config_reg[AUX_FN_PIN7] |=>
            pin.oe[7] && (pin.o[7] == $past(stop_go_in));
    endproperty
    a_stop_go: assert property (p_stop_go) // RULE_13
        else $error("pin 7 not stop/go");

    property p_irq_path;
        @(posedge mclk) disable iff (rst)
        (trig[0] && !pin_irq_mask_reg[0]) |=> ##1 irq;
    endproperty
    a_irq_path: assert property (p_irq_path) // RULE_10
        else $error("unmasked trigger gave no interrupt");

    property p_level_hold;
        @(posedge mclk) disable iff (rst)
        (rd_stat && trig[1]) |=> pin_irq_status_reg[1];
    endproperty
    a_level_hold: assert property (p_level_hold) // RULE_21
        else $error("active trigger lost on read");

    property p_pullup_off;
        @(posedge mclk) disable iff (rst)
        (!pin_direction_reg[6] && pin_drive_config_reg[6]) |=> !pullup_en[0];
    endproperty
    a_pullup_off: assert property (p_pullup_off) // RULE_12
        else $error("pull-up on in push-pull mode");

endmodule : aux_pin_interface
`default_nettype wire

// >>> hdl/aux_pkg.sv
// Constants, types and register map of the auxiliary pin block
// Functional notes
// [RULE_01] Pin roles follow the strapped operating mode
// [RULE_02] All pins are inputs after reset
// [RULE_03] Direction 1 means input; read captures level
// [RULE_04] Direction 0 drives output register onto pin
// [RULE_05] Drive bit 0 open-drain, 1 push-pull
// [RULE_06] Input register reads the real pin level
// [RULE_07] Pin 5 function select picks alternate output
// [RULE_08] Pin 5 source select: frame sync or bit clock
// [RULE_09] Pins 6, 7 interrupt-capable I/O, masked at reset
// [RULE_10] Input trigger sets status; mask gates interrupt
// [RULE_11] Per-pin edge or level trigger choice
// [RULE_12] Pull-ups on 6, 7 off only in push-pull output
// [RULE_13] Pin 7 function select outputs stop/go bit
// [RULE_14] Pin 4 carries multiframe marker, I/O ignored
// [RULE_15] Marker pin direction depends on operating mode
// [RULE_16] Line modes take channel from three straps
// [RULE_17] Slow data clock allows channels 0 to 2
// [RULE_18] Strap channel offsets routed timeslot selection
// [RULE_19] Frame is a multiplex of eight channels
// [RULE_20] Interrupt pins pass a two-flop synchroniser
// [RULE_21] Status read clears, unless level still active
package aux_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] AUX_OFS_DIR = 4'h0;
    localparam logic [3:0] AUX_OFS_OUT = 4'h1;
    localparam logic [3:0] AUX_OFS_IN = 4'h2;
    localparam logic [3:0] AUX_OFS_DRV = 4'h3;
    localparam logic [3:0] AUX_OFS_FUNC = 4'h4;
    localparam logic [3:0] AUX_OFS_IRQ_STAT = 4'h5;
    localparam logic [3:0] AUX_OFS_IRQ_MASK = 4'h6;
    localparam logic [3:0] AUX_OFS_STRAP = 4'h7;

    // Reset values
    localparam logic [7:0] AUX_RST_DIR = 8'hff;
    localparam logic [7:0] AUX_RST_OUT = 8'hff;
    localparam logic [7:0] AUX_RST_DRV = 8'h00;
    localparam logic [5:0] AUX_RST_FUNC = 6'h00;
    localparam logic [1:0] AUX_RST_MASK = 2'h3;

    // Field positions in the function configuration register
    localparam int AUX_FN_PIN4 = 0;
    localparam int AUX_FN_PIN5 = 1;
    localparam int AUX_FN_SRC = 2;
    localparam int AUX_FN_PIN7 = 3;
    localparam int AUX_FN_TRIG_A = 4;
    localparam int AUX_FN_TRIG_B = 5;

    // Channel limits
    localparam logic [2:0] AUX_SLOW_MAX_CH = 3'h2;

    // Strapped operating modes, Gray order along the usual list
    typedef enum logic [2:0] {
        AUX_SUBSCRIBER = 3'b000,
        AUX_TRUNK_LT = 3'b001,
        AUX_SUBSCR_LT = 3'b011,
        AUX_NET_TERM = 3'b010,
        AUX_SMART_NT = 3'b110
    } aux_mode_e;

    // One register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } aux_req_s;

    // Output and output-enable view of the eight pins
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } aux_pin_drv_s;

endpackage : aux_pkg

// >>> test/aux_board_model.sv
// Board model: external drivers, pull-ups and floating lines on the pins
`timescale 1ns/1ps
`default_nettype none
module aux_board_model (
    input wire logic mclk,
    input wire aux_pkg::aux_pin_drv_s pin,
    input wire logic [1:0] pullup_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_i
);
    import aux_pkg::*;
    logic [7:0] float_pat = 8'h5a; // Level of a line nobody holds
    logic [7:0] pull; // Pull-up present per pin

    // A released line with no pull-up wanders, so nothing may rely on it
    always @(posedge mclk)
    begin
        float_pat <= ~float_pat;
    end

    // Only pins 6 and 7 carry switchable pull-ups
    assign pull = {pullup_en, 6'h00};

    // Wired level: a low driver wins, then board drivers, then pull-ups
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin.oe[i] && !pin.o[i])
                pin_i[i] = 1'b0;
            else if (ext_en[i])
                pin_i[i] = ext_val[i];
            else if (pin.oe[i] || pull[i])
                pin_i[i] = 1'b1;
            else
                pin_i[i] = float_pat[i];
        end
    end
endmodule : aux_board_model
`default_nettype wire

// >>> test/aux_pin_interface_tb_top.sv
// Self-checking bench for the auxiliary pin block
`timescale 1ns/1ps
`default_nettype none
module aux_pin_interface_tb_top;
    import aux_pkg::*;
    logic mclk = 1'b0; // 50 MHz clock
    logic rst = 1'b1; // Synchronous reset
    aux_req_s req = '0; // Register port request
    logic [7:0] rdata;
    logic [2:0] mode_strap = 3'b000;
    logic data_clock_fast = 1'b0;
    logic [7:0] pin_i;
    aux_pin_drv_s pin;
    logic [1:0] pullup_en;
    logic frame_sync = 1'b0;
    logic bit_clock = 1'b0;
    logic stop_go_in = 1'b0;
    logic channel_tick = 1'b0; // Steps the slot counter
    logic marker_tx = 1'b0;
    logic marker_rx;
    logic [2:0] timeslot_offset;
    logic channel_invalid;
    logic own_channel;
    logic irq;
    logic [7:0] ext_en = 8'h00; // Board drivers on
    logic [7:0] ext_val = 8'h00; // Board driver levels
    int fails = 0;
    int n_checks = 0;
    logic [7:0] sh_out; // Shadow of the output register
    logic [7:0] r;
    logic [7:0] v;
    logic [2:0] m;
    logic line; // Strapped into a line termination mode
    logic outm; // Marker pin is an output
    logic [3:0] ofs [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h8};
    logic [7:0] rval [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h03, 8'h00};
    logic [2:0] modes [$] = '{3'b000, 3'b001, 3'b011, 3'b010, 3'b110};

    // Design under test; the board model closes the pin loop
    aux_pin_interface dut (.mclk(mclk), .rst(rst), .req(req),
        .rdata(rdata), .mode_strap(mode_strap),
        .data_clock_fast(data_clock_fast), .pin_i(pin_i), .pin(pin),
        .pullup_en(pullup_en), .frame_sync(frame_sync),
        .bit_clock(bit_clock), .channel_tick(channel_tick),
        .stop_go_in(stop_go_in), .marker_tx(marker_tx),
        .marker_rx(marker_rx), .timeslot_offset(timeslot_offset),
        .channel_invalid(channel_invalid), .own_channel(own_channel),
        .irq(irq));

    aux_board_model board (.mclk(mclk), .pin(pin), .pullup_en(pullup_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

    // Free-running clock
    initial
    begin
        forever #10 mclk = ~mclk;
    end

    // Compare one value; case equality so unknowns never match
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr

    // One-cycle register read; data stand only in the next cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Let n edges pass and the outputs settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // Change what the board drives
    task automatic ext(input logic [7:0] en, input logic [7:0] val);
        @(posedge mclk);
        ext_en <= en;
        ext_val <= val;
    endtask : ext

    // Reset with straps held; straps are only sampled while reset is high
    task automatic do_reset(input logic [2:0] md, input logic [2:0] ch,
        input logic fast, input int n);
        @(posedge mclk);
        rst <= 1'b1;
        mode_strap <= md;
        data_clock_fast <= fast;
        ext_en <= 8'h07;
        ext_val <= {5'h00, ch};
        repeat (n) @(posedge mclk);
        rst <= 1'b0;
        ext_en <= 8'h00;
        tick(1);
    endtask : do_reset

    // Verdict, reached from the end of the tests or the watchdog
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Watchdog: the tests need well under a tenth of this span
    initial
    begin
        #200000;
        fails++;
        summarize();
    end

    // Main sequence
    initial
    begin
        r = $urandom(9);
        do_reset(3'b000, 3'h0, 1'b0, 10);
        chk("oe after reset", pin.oe, 8'h00);
        chk("pullups", {6'h00, pullup_en}, 8'h03);
        chk("irq", {7'h00, irq}, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            rd(ofs[i], v);
            chk("reset reg", v, rval[i]);
        end
        // Push-pull outputs, then open-drain with the board driving random levels
        sh_out = $urandom;
        wr(4'h3, 8'hff);
        wr(4'h1, sh_out);
        wr(4'h0, 8'h00);
        tick(2);
        chk("pin o", pin.o, sh_out);
        chk("pin oe", pin.oe, 8'hff);
        chk("pullups pp", {6'h00, pullup_en}, 8'h00);
        wr(4'h3, 8'h00);
        r = $urandom;
        ext(8'hff, r);
        tick(2);
        chk("od oe", pin.oe, ~sh_out);
        chk("od o", pin.o, 8'h00);
        chk("pullups od", {6'h00, pullup_en}, 8'h03);
        rd(4'h2, v);
        chk("read back", v, sh_out & r);
        wr(4'h0, 8'hff);
        tick(2);
        rd(4'h2, v);
        chk("input level", v, r);
        // Alternate functions on pins 4, 5 and 7, random sources
        ext(8'h00, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            r = $urandom;
            wr(4'h4, {4'h0, 1'b1, r[4], 2'b11});
            @(posedge mclk);
            frame_sync <= r[0];
            bit_clock <= r[1];
            stop_go_in <= r[2];
            marker_tx <= r[3];
            tick(3);
            chk("alt oe", pin.oe & 8'hb0, 8'hb0);
            chk("alt o", pin.o & 8'hb0, {r[2], 1'b0, r[4] ? r[1] : r[0],
                r[3], 4'h0});
            chk("sgo pullup", {6'h00, pullup_en}, 8'h01);
        end
        wr(4'h4, 8'h00);
        // Edge interrupt on pin 6, unmasked
        ext(8'hc0, 8'hc0);
        wr(4'h6, 8'h00);
        tick(6);
        rd(4'h5, v);
        ext(8'hc0, 8'h80);
        tick(6);
        chk("irq edge", {7'h00, irq}, 8'h01);
        rd(4'h5, v);
        chk("status edge", v, 8'h01);
        tick(3);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        rd(4'h5, v);
        chk("status cleared", v, 8'h00);
        // Pin 7 falls while masked, then is unmasked
        wr(4'h6, 8'h02);
        ext(8'hc0, 8'h00);
        tick(6);
        chk("irq masked", {7'h00, irq}, 8'h00);
        wr(4'h6, 8'h00);
        tick(3);
        chk("irq unmasked", {7'h00, irq}, 8'h01);
        rd(4'h5, v);
        chk("status masked", v, 8'h02);
        // Level trigger on pin 6 survives a read while low
        wr(4'h4, 8'h10);
        tick(6);
        rd(4'h5, v);
        chk("level 1", v, 8'h01);
        rd(4'h5, v);
        chk("level 2", v, 8'h01);
        ext(8'hc0, 8'hc0);
        tick(6);
        rd(4'h5, v);
        chk("level sticky", v, 8'h01);
        rd(4'h5, v);
        chk("level gone", v, 8'h00);
        // Every strapped mode with channel straps and clock rate
        for (int i = 0; i < 8; i++)
        begin
            m = modes[i % 5];
            line = m == 3'b001 || m == 3'b011 || m == 3'b010;
            outm = m == 3'b000 || m == 3'b001;
            do_reset(m, i[2:0], i >= 6, 3);
            chk("slot", {5'h00, timeslot_offset},
                line ? 8'(i) : 8'h00);
            chk("invalid", {7'h00, channel_invalid},
                {7'h00, line && i > 2 && i < 6});
            rd(4'h7, v);
            chk("strap reg", v,
                {line && i > 2 && i < 6, line, m, i[2:0]});
            r = $urandom;
            wr(4'h3, 8'hff);
            wr(4'h4, 8'h01);
            wr(4'h0, 8'h00);
            ext(8'h10, r);
            @(posedge mclk);
            marker_tx <= r[0];
            tick(3);
            chk("mode oe", pin.oe & 8'h1f,
                {3'h0, outm, 1'b1, {3{!line}}});
            if (outm)
                chk("marker out", {7'h00, pin.o[4]}, {7'h00, r[0]});
            else
                chk("marker in", {7'h00, marker_rx}, {7'h00, r[4]});
        end
        // Frame sync restarts the slot count; strapped channel here is 7
        @(posedge mclk);
        frame_sync <= 1'b1;
        @(posedge mclk);
        frame_sync <= 1'b0;
        channel_tick <= 1'b1;
        for (int j = 0; j < 8; j++)
        begin
            tick(1);
            chk("own slot", {7'h00, own_channel}, {7'h00, j == 7});
        end
        @(posedge mclk);
        channel_tick <= 1'b0;
        summarize();
    end
endmodule : aux_pin_interface_tb_top
`default_nettype wire
